// file: core/flash_cmd_pkg.sv
package flash_cmd_pkg;

	// Flash-side geometry
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int NPART = 4;
	localparam int NBLK = 8;
	localparam int PART_HI = 19;
	localparam int PART_LO = 18;
	localparam int BLK_HI = 19;
	localparam int BLK_LO = 17;

	// Command codes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_IDENT = 8'h90;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h10;
	localparam logic [7:0] CMD_FAST_SETUP = 8'h30;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
	localparam logic [7:0] CMD_LOCK_DOWN = 8'h2F;
	localparam logic [7:0] CMD_SET_CONFIG = 8'h03;
	localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;

	// Protection lock word and its location
	localparam logic [ADDR_W-1:0] LOCK_PROT_LOC = 20'h00080;
	localparam logic [DATA_W-1:0] LOCK_PROT_DATA = 16'hFFFD;

	// Identifier offsets
	localparam logic [7:0] ID_MAKER = 8'h00;
	localparam logic [7:0] ID_DEVICE = 8'h01;
	localparam logic [7:0] ID_LOCK = 8'h02;
	localparam logic [7:0] ID_CONFIG = 8'h05;
	localparam logic [7:0] ID_PROT_LOCK = 8'h80;
	// Arbitrary identity values
	localparam logic [DATA_W-1:0] MAKER_CODE = 16'h00A5;
	localparam logic [DATA_W-1:0] PART_CODE = 16'h5A01;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam logic [15:0] CFG_RESET = 16'h8000;
	localparam logic [NBLK-1:0] LOCK_RESET = 8'hFF;

	// Wishbone register offsets
	localparam int WB_ADR_W = 5;
	localparam logic [4:0] REG_STATUS = 5'h00;
	localparam logic [4:0] REG_CONFIG = 5'h04;
	localparam logic [4:0] REG_CTRL = 5'h08;
	localparam logic [4:0] REG_PART = 5'h0C;
	localparam logic [4:0] REG_LOCK = 5'h10;
	localparam logic [4:0] REG_ENGINE = 5'h14;
	localparam int CTRL_WP_BIT = 0;

	typedef enum logic [3:0] {
		RD_ARRAY = 4'b0001,
		RD_STATUS = 4'b0010,
		RD_IDENT = 4'b0100,
		RD_QUERY = 4'b1000
	} read_state_t;

	typedef enum logic [5:0] {
		SU_NONE = 6'b000001,
		SU_PROG = 6'b000010,
		SU_FAST = 6'b000100,
		SU_ERASE = 6'b001000,
		SU_LOCK = 6'b010000,
		SU_PROT = 6'b100000
	} setup_t;

	typedef enum logic [5:0] {
		E_IDLE = 6'b000001,
		E_PROG = 6'b000010,
		E_ERASE = 6'b000100,
		E_PSUSP = 6'b001000,
		E_ESUSP = 6'b010000,
		E_FAST = 6'b100000
	} eng_state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PROG = 3'h1,
		OP_ERASE = 3'h2,
		OP_FAST = 3'h3,
		OP_FAST_DATA = 3'h4,
		OP_PROT = 3'h5,
		OP_PROT_LOCK = 3'h6
	} eng_op_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} flash_bus_t;

	typedef struct packed {
		eng_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} eng_cmd_t;

	typedef struct packed {
		logic erase;
		logic prog;
		logic supply;
		logic lock;
	} err_t;

endpackage

// file: core/flash_command_decoder.sv
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module flash_command_decoder
	import flash_cmd_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Flash bus
	input wire flash_bus_t bus_i,
	input wire logic [DATA_W-1:0] array_data_i,
	input wire logic [7:0] cfi_data_i,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic [15:0] cfg_o,
	// Write state engine
	output eng_cmd_t eng_cmd_o,
	output logic eng_start_o,
	output logic eng_suspend_o,
	output logic eng_resume_o,
	input wire logic eng_done_i,
	input wire err_t eng_err_i
);

	localparam int PW = PART_HI - PART_LO + 1;
	localparam int BW = BLK_HI - BLK_LO + 1;

	function automatic logic [PW-1:0] part_of(logic [ADDR_W-1:0] a);
		return a[PART_HI:PART_LO];
	endfunction

	function automatic logic [BW-1:0] block_of(logic [ADDR_W-1:0] a);
		return a[BLK_HI:BLK_LO];
	endfunction

	read_state_t rd_state [NPART];
	setup_t setup [NPART];
	eng_state_t eng;
	logic [PW-1:0] busy_part;
	err_t err;
	logic [NBLK-1:0] locked;
	logic [NBLK-1:0] down;
	logic prot_locked;
	logic write_protect;
	logic prev_we_n;
	logic prev_ce_n;
	logic prev_oe_n;
	logic [7:0] status_shown;

	read_state_t next_rd [NPART];
	setup_t next_su [NPART];
	eng_state_t next_eng;
	logic [PW-1:0] next_bp;
	err_t next_err;
	logic [NBLK-1:0] next_lk;
	logic [NBLK-1:0] next_dn;
	logic [15:0] next_cfg;
	logic next_prot;
	logic next_start;
	logic next_susp;
	logic next_res;
	eng_cmd_t next_cmd;

	// Write strobe: address and data are taken at the WE rising edge
	wire wr = ~prev_we_n & bus_i.we_n & ~bus_i.ce_n;
	wire [PW-1:0] wr_part = part_of(bus_i.addr);
	wire [BW-1:0] wr_blk = block_of(bus_i.addr);
	wire [7:0] code = bus_i.data[7:0];
	wire running = (eng == E_PROG) || (eng == E_ERASE);
	wire suspended = (eng == E_PSUSP) || (eng == E_ESUSP);
	wire busy_p = (running || eng == E_FAST) && (wr_part == busy_part);
	wire can_start = (eng == E_IDLE) && !write_protect;
	wire is_prot_lock = (bus_i.addr == LOCK_PROT_LOC) &&
		(bus_i.data == LOCK_PROT_DATA);

	logic other_pending;
	always_comb begin
		other_pending = 1'b0;
		for (int i = 0; i < NPART; i++) begin
			if (setup[i] != SU_NONE && i != int'(wr_part)) begin
				other_pending = 1'b1;
			end
		end
	end

	// Command front end: decides the next state of every partition
	logic seq_err;
	logic clr_err;
	logic launch;
	eng_op_t launch_op;
	eng_state_t launch_st;
	always_comb begin
		next_rd = rd_state;
		next_su = setup;
		next_eng = eng;
		next_bp = busy_part;
		next_lk = locked;
		next_dn = down;
		next_cfg = cfg_o;
		next_prot = prot_locked;
		next_start = 1'b0;
		next_susp = 1'b0;
		next_res = 1'b0;
		next_cmd = eng_cmd_o;
		seq_err = 1'b0;
		clr_err = 1'b0;
		launch = 1'b0;
		launch_op = OP_NONE;
		launch_st = E_IDLE;
		if (wr) begin
			if (eng == E_FAST) begin
				// Only data words for the running partition count
				if (wr_part == busy_part) begin
					next_start = 1'b1;
					next_cmd = '{OP_FAST_DATA, bus_i.addr, bus_i.data};
				end
			end else if (setup[wr_part] != SU_NONE) begin
				next_su[wr_part] = SU_NONE;
				next_rd[wr_part] = RD_STATUS;
				case (setup[wr_part])
					SU_PROG: begin
						launch = 1'b1;
						launch_op = OP_PROG;
						launch_st = E_PROG;
					end
					SU_FAST: begin
						if (code == CMD_CONFIRM) begin
							launch = 1'b1;
							launch_op = OP_FAST;
							launch_st = E_FAST;
						end else begin
							seq_err = 1'b1;
						end
					end
					SU_ERASE: begin
						if (code == CMD_CONFIRM) begin
							// Confirm cycle address picks the block
							launch = 1'b1;
							launch_op = OP_ERASE;
							launch_st = E_ERASE;
						end else begin
							seq_err = 1'b1;
						end
					end
					SU_LOCK: begin
						case (code)
							CMD_LOCK_BLOCK: next_lk[wr_blk] = 1'b1;
							CMD_LOCK_DOWN: begin
								next_lk[wr_blk] = 1'b1;
								next_dn[wr_blk] = 1'b1;
							end
							CMD_CONFIRM: begin
								if (!down[wr_blk]) begin
									next_lk[wr_blk] = 1'b0;
								end
							end
							CMD_SET_CONFIG: begin
								next_cfg = bus_i.addr[15:0];
								next_rd[wr_part] = RD_ARRAY;
							end
							default: seq_err = 1'b1;
						endcase
					end
					SU_PROT: begin
						launch = 1'b1;
						launch_op = is_prot_lock ? OP_PROT_LOCK : OP_PROT;
						launch_st = E_PROG;
					end
					default: seq_err = 1'b1;
				endcase
			end else if (other_pending) begin
				// A write elsewhere broke a pending sequence
				seq_err = 1'b1;
				for (int i = 0; i < NPART; i++) begin
					if (setup[i] != SU_NONE) begin
						next_su[i] = SU_NONE;
						next_rd[i] = RD_STATUS;
					end
				end
			end else if (busy_p) begin
				if (code == CMD_READ_STATUS) begin
					next_rd[wr_part] = RD_STATUS;
				end else if (code == CMD_SUSPEND) begin
					next_susp = 1'b1;
					next_eng = (eng == E_PROG) ? E_PSUSP : E_ESUSP;
				end
			end else begin
				case (code)
					CMD_READ_ARRAY: next_rd[wr_part] = RD_ARRAY;
					CMD_READ_STATUS: next_rd[wr_part] = RD_STATUS;
					CMD_READ_IDENT: next_rd[wr_part] = RD_IDENT;
					CMD_QUERY: next_rd[wr_part] = RD_QUERY;
					CMD_CLEAR_STATUS: clr_err = 1'b1;
					CMD_SUSPEND: begin
						if (running) begin
							next_susp = 1'b1;
							next_eng = (eng == E_PROG) ? E_PSUSP : E_ESUSP;
						end
					end
					CMD_CONFIRM: begin
						if (suspended) begin
							next_res = 1'b1;
							next_eng = (eng == E_PSUSP) ? E_PROG : E_ERASE;
						end
					end
					CMD_PROG_SETUP, CMD_PROG_ALT: begin
						next_su[wr_part] = SU_PROG;
						next_rd[wr_part] = RD_STATUS;
					end
					CMD_FAST_SETUP: begin
						next_su[wr_part] = SU_FAST;
						next_rd[wr_part] = RD_STATUS;
					end
					CMD_ERASE_SETUP: begin
						next_su[wr_part] = SU_ERASE;
						next_rd[wr_part] = RD_STATUS;
					end
					CMD_LOCK_SETUP: begin
						next_su[wr_part] = SU_LOCK;
						next_rd[wr_part] = RD_STATUS;
					end
					CMD_PROT_SETUP: begin
						next_su[wr_part] = SU_PROT;
						next_rd[wr_part] = RD_STATUS;
					end
					default: ; // Unassigned codes do nothing
				endcase
			end
		end
		// Start is refused while the engine holds another operation
		if (launch && can_start) begin
			next_start = 1'b1;
			next_cmd = '{launch_op, bus_i.addr, bus_i.data};
			next_eng = launch_st;
			next_bp = wr_part;
			next_rd[wr_part] = RD_STATUS;
			if (launch_op == OP_PROT_LOCK) begin
				next_prot = 1'b1;
			end
		end
		if (eng_done_i && (running || eng == E_FAST)) begin
			next_eng = E_IDLE;
		end
	end

	// Engine and sequence errors win over a clear in the same cycle
	wire refused = launch && write_protect;
	assign next_err = (clr_err ? '0 : err) | eng_err_i |
		err_t'{erase: seq_err, prog: seq_err, supply: refused,
		lock: 1'b0};

	wire [7:0] status_word = {eng == E_IDLE || suspended,
		eng == E_ESUSP, err.erase, err.prog, err.supply,
		eng == E_PSUSP, err.lock, 1'b0};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NPART; i++) begin
				rd_state[i] <= RD_ARRAY;
				setup[i] <= SU_NONE;
			end
			eng <= E_IDLE;
			busy_part <= '0;
			err <= '0;
			locked <= LOCK_RESET;
			down <= '0;
			cfg_o <= CFG_RESET;
			prot_locked <= 1'b0;
		end else begin
			rd_state <= next_rd;
			setup <= next_su;
			eng <= next_eng;
			busy_part <= next_bp;
			err <= next_err;
			locked <= next_lk;
			down <= next_dn;
			cfg_o <= next_cfg;
			prot_locked <= next_prot;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eng_cmd_o <= '{OP_NONE, '0, '0};
			eng_start_o <= 1'b0;
			eng_suspend_o <= 1'b0;
			eng_resume_o <= 1'b0;
		end else begin
			eng_cmd_o <= next_cmd;
			eng_start_o <= next_start;
			eng_suspend_o <= next_susp;
			eng_resume_o <= next_res;
		end
	end

	// Read path
	wire [PW-1:0] rd_part = part_of(bus_i.addr);
	wire [BW-1:0] rd_blk = block_of(bus_i.addr);
	wire read_state_t cur_rd = rd_state[rd_part];
	wire [7:0] id_off = bus_i.addr[7:0];
	wire [DATA_W-1:0] id_word =
		(id_off == ID_MAKER) ? MAKER_CODE :
		(id_off == ID_DEVICE) ? PART_CODE :
		(id_off == ID_LOCK) ? {14'h0000, down[rd_blk], locked[rd_blk]} :
		(id_off == ID_CONFIG) ? cfg_o :
		(id_off == ID_PROT_LOCK) ? {15'h0000, prot_locked} :
		16'h0000;
	wire [DATA_W-1:0] rd_word =
		(cur_rd == RD_STATUS) ? {8'h00, status_shown} :
		(cur_rd == RD_IDENT) ? id_word :
		(cur_rd == RD_QUERY) ? {8'h00, cfi_data_i} :
		array_data_i;
	// Polling software must toggle CE or OE to see progress
	wire toggled = (bus_i.ce_n != prev_ce_n) || (bus_i.oe_n != prev_oe_n);
	wire refresh = toggled || !(running || eng == E_FAST);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_we_n <= 1'b1;
			prev_ce_n <= 1'b1;
			prev_oe_n <= 1'b1;
			status_shown <= STATUS_RESET;
			dq_o <= '0;
			dq_oe_o <= 1'b0;
		end else begin
			prev_we_n <= bus_i.we_n;
			prev_ce_n <= bus_i.ce_n;
			prev_oe_n <= bus_i.oe_n;
			if (refresh) begin
				status_shown <= status_word;
			end
			dq_o <= rd_word;
			dq_oe_o <= ~bus_i.ce_n & ~bus_i.oe_n & bus_i.we_n;
		end
	end

	// Wishbone slave: one wait state, unmapped reads give zero
	wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire ctrl_wr = wb_hit & wb_we_i & (wb_adr_i == REG_CTRL) & wb_sel_i[0];
	wire [31:0] wb_rd =
		(wb_adr_i == REG_STATUS) ? {24'h000000, status_word} :
		(wb_adr_i == REG_CONFIG) ? {16'h0000, cfg_o} :
		(wb_adr_i == REG_CTRL) ? {31'h00000000, write_protect} :
		(wb_adr_i == REG_PART) ? {16'h0000, rd_state[3], rd_state[2],
			rd_state[1], rd_state[0]} :
		(wb_adr_i == REG_LOCK) ? {16'h0000, down, locked} :
		(wb_adr_i == REG_ENGINE) ? {24'h000000, 2'b00, eng} :
		32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			write_protect <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
			if (wb_hit) begin
				wb_dat_o <= wb_rd;
			end
			if (ctrl_wr) begin
				write_protect <= wb_dat_i[CTRL_WP_BIT];
			end
		end
	end

endmodule

// file: dv/flash_cmd_assertions.sv
`timescale 1ns/1ps
module flash_cmd_assertions
	import flash_cmd_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire flash_bus_t bus_i,
	input wire logic dq_oe_o,
	input wire logic [15:0] cfg_o,
	input wire eng_cmd_t eng_cmd_o,
	input wire logic eng_start_o,
	input wire logic eng_suspend_o,
	input wire logic eng_resume_o
);
	logic we_q;
	wire taken = !we_q && bus_i.we_n && !bus_i.ce_n;
	wire [7:0] cd = bus_i.data[7:0];
	wire rd = !bus_i.ce_n && !bus_i.oe_n && bus_i.we_n;
	always_ff @(posedge clk_i) begin
		we_q <= rst_i | bus_i.we_n;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_rst;
		$fell(rst_i) |-> cfg_o == CFG_RESET && !dq_oe_o;
	endproperty
	property p_ack;
		s_req |=> s_ack;
	endproperty
	property p_start;
		eng_start_o |-> $past(taken) ##1 !eng_start_o;
	endproperty
	property p_prog;
		eng_start_o && eng_cmd_o.op == OP_PROG |->
			eng_cmd_o.data == $past(bus_i.data) &&
			eng_cmd_o.addr == $past(bus_i.addr);
	endproperty
	property p_erase;
		eng_start_o && eng_cmd_o.op == OP_ERASE |->
			$past(cd) == CMD_CONFIRM && eng_cmd_o.addr == $past(bus_i.addr);
	endproperty
	property p_susp;
		eng_suspend_o |-> $past(taken && cd == CMD_SUSPEND);
	endproperty
	property p_res;
		eng_resume_o |-> $past(taken && cd == CMD_CONFIRM);
	endproperty
	property p_cfg;
		!$stable(cfg_o) |-> cfg_o == $past(bus_i.addr[15:0]) &&
			$past(taken && cd == CMD_SET_CONFIG);
	endproperty
	property p_oe;
		rd ##1 rd |-> dq_oe_o;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_ack: assert property (p_ack) else $error("bad ack");
	a_start: assert property (p_start) else $error("bad start");
	a_prog: assert property (p_prog) else $error("bad program");
	a_erase: assert property (p_erase) else $error("bad erase");
	a_susp: assert property (p_susp) else $error("bad suspend");
	a_res: assert property (p_res) else $error("bad resume");
	a_cfg: assert property (p_cfg) else $error("bad config");
	a_oe: assert property (p_oe) else $error("no output");
endmodule
bind flash_command_decoder flash_cmd_assertions chk_u (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .bus_i, .dq_oe_o, .cfg_o, .eng_cmd_o,
	.eng_start_o, .eng_suspend_o, .eng_resume_o);

// file: dv/eng_model.sv
`timescale 1ns/1ps
module eng_model
	import flash_cmd_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests
	input wire logic start_i,
	input wire logic suspend_i,
	input wire logic resume_i,
	input wire logic [7:0] dly_i,
	input wire err_t err_req_i,
	// Answers
	output logic done_o,
	output err_t err_o
);
	logic [7:0] cnt;
	logic run;
	logic hold;
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		err_o <= '0;
		if (rst_i) begin
			run <= 1'b0;
			hold <= 1'b0;
		end else if (start_i) begin
			run <= 1'b1;
			cnt <= dly_i;
		end else if (suspend_i) begin
			hold <= 1'b1; // Parked until resumed
		end else if (resume_i) begin
			hold <= 1'b0;
		end else if (run && !hold) begin
			if (cnt == 8'h00) begin
				run <= 1'b0;
				done_o <= 1'b1;
				err_o <= err_req_i; // Flags set for the done cycle only, cleared next cycle
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR %0t %h %h", $time, a, b); end end
module tb;
	import flash_cmd_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, oe_q = 0;
	logic [3:0] wb_sel_i = '0;
	logic [WB_ADR_W-1:0] wb_adr_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, ew;
	logic wb_ack_o, dq_oe_o, eng_start_o, eng_suspend_o, eng_resume_o;
	logic eng_done_i;
	flash_bus_t bus_i = {3'h7, 36'h0};
	logic [15:0] dq_o, cfg_o, akey = '0, ef;
	eng_cmd_t eng_cmd_o, ee;
	err_t eng_err_i, err_req = '0;
	int error_cnt = 0, cmp_count = 0, cyc_n = 0;
	logic [31:0] qw[$];
	logic [15:0] qf[$];
	eng_cmd_t qe[$];
	wire [15:0] array_data_i = bus_i.addr[15:0] ^ akey;
	wire [7:0] cfi_data_i = bus_i.addr[7:0] + 8'h11;
	flash_command_decoder dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .bus_i, .array_data_i, .cfi_data_i, .dq_o, .dq_oe_o,
		.cfg_o, .eng_cmd_o, .eng_start_o, .eng_suspend_o, .eng_resume_o,
		.eng_done_i, .eng_err_i);
	eng_model pe_u (.clk_i, .rst_i, .start_i(eng_start_o),
		.suspend_i(eng_suspend_o), .resume_i(eng_resume_o),
		.dly_i(8'd60), .err_req_i(err_req), .done_o(eng_done_i),
		.err_o(eng_err_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic complete_run;
		if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(logic we, logic [4:0] a, logic [31:0] d, e);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
			{2'b11, we, a, 4'hF, d};
		if (!we) qw.push_back(e);
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic fw(logic [19:0] a, logic [15:0] d);
		@(posedge clk_i);
		bus_i <= {3'b010, a, d};
		@(posedge clk_i);
		bus_i.we_n <= 1'b1;
		@(posedge clk_i);
		bus_i.ce_n <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	// Reads toggle chip select so running status is refreshed
	task automatic fr(logic [19:0] a, logic [15:0] e);
		@(posedge clk_i);
		bus_i <= {3'b001, a, 16'h0};
		qf.push_back(e);
		repeat (2) @(posedge clk_i);
		bus_i <= {3'b111, a, 16'h0};
	endtask
	task automatic wdone;
		do @(posedge clk_i); while (eng_done_i !== 1'b1);
		repeat (2) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		oe_q <= dq_oe_o;
		if (wb_ack_o && !wb_we_i) begin
			ew = qw.pop_front();
			`CHK(wb_dat_o, ew)
		end
		if (dq_oe_o && !oe_q) begin
			ef = qf.pop_front();
			`CHK(dq_o, ef)
		end
		if (eng_start_o) begin
			ee = qe.pop_front();
			`CHK(eng_cmd_o, ee)
		end
		cyc_n++;
		if (cyc_n == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		int p;
		logic [19:0] a, b, r;
		logic [15:0] c, d;
		logic [7:0] rc[4];
		rc = '{CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_IDENT, CMD_QUERY};
		void'($urandom(32'h565e9e41));
		akey = 16'($urandom);
		a = 20'($urandom);
		p = int'(a[19:18]);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, REG_STATUS, 0, 32'h80);
		wb(0, REG_PART, 0, 32'h1111);
		wb(0, REG_CONFIG, 0, 32'h8000);
		wb(0, REG_LOCK, 0, 32'hFF);
		wb(0, 5'h18, 0, 0);
		for (int i = 0; i < 4; i++) begin
			fw(a, {8'h00, rc[i]});
			wb(0, REG_PART, 0, 32'h1111 & ~(32'hF << 4*p) | (32'(1 << i) << 4*p));
		end
		fr(a, {8'h00, a[7:0] + 8'h11});
		a = {a[19:18] + 2'd1, 18'($urandom)};
		r = {a[19:18] + 2'd1, 18'($urandom)};
		d = 16'($urandom);
		fr(r, r[15:0] ^ akey);
		fw(a, {8'h00, CMD_PROG_SETUP});
		fr(r, r[15:0] ^ akey);
		fr(a, 16'h0080);
		qe.push_back({OP_PROG, a, d});
		fw(a, d);
		fr(a, 16'h0000);
		fw(a, 16'h00FF);
		fr(a, 16'h0000);
		fw(r, 16'h00B0);
		fr(a, 16'h0084);
		wb(0, REG_ENGINE, 0, 32'h8);
		fw(r, 16'h00D0);
		fr(a, 16'h0000);
		wdone();
		fr(a, 16'h0080);
		fw(a, 16'h0020);
		fw(a, 16'h00FF);
		fr(a, 16'h00B0);
		fw(r, 16'h0050);
		fr(a, 16'h0080);
		b = a ^ 20'h20000;
		fw(a, 16'h0020);
		qe.push_back({OP_ERASE, b, 16'h00D0});
		fw(b, 16'h00D0);
		err_req <= 4'b1000;
		wdone();
		fr(a, 16'h00A0);
		fw(a, 16'h0050);
		wb(1, REG_CTRL, 1, 0);
		wb(0, REG_CTRL, 0, 1);
		fw(a, 16'h0010);
		fw(a, d);
		fr(a, 16'h0088);
		wb(1, REG_CTRL, 0, 0);
		fw(a, 16'h0050);
		fw(a, 16'h0060);
		fw(a, 16'h00D0);
		wb(0, REG_LOCK, 0, {24'h0, ~(8'h1 << a[19:17])});
		fw(a, 16'h0060);
		fw(a, 16'h002F);
		fw(a, 16'h0060);
		fw(a, 16'h00D0);
		wb(0, REG_LOCK, 0, {16'h0, 8'h1 << a[19:17], 8'hFF});
		fw(a, 16'h0090);
		fr({a[19:17], 17'h2}, 16'h0003);
		fw(a, 16'h0060);
		fw(a, 16'h0077);
		fr(a, 16'h00B0);
		fw(a, 16'h0050);
		c = 16'($urandom);
		fw({a[19:16], c}, 16'h0060);
		fw({a[19:16], c}, 16'h0003);
		wb(0, REG_CONFIG, 0, {16'h0, c});
		fr({a[19:16], c}, c ^ akey);
		fw(LOCK_PROT_LOC, 16'h00C0);
		qe.push_back({OP_PROT_LOCK, LOCK_PROT_LOC, LOCK_PROT_DATA});
		fw(LOCK_PROT_LOC, LOCK_PROT_DATA);
		wdone();
		fw(20'h00081, 16'h00C0);
		qe.push_back({OP_PROT, 20'h00081, d});
		fw(20'h00081, d);
		wdone();
		fw(20'h00000, 16'h0090);
		fr(LOCK_PROT_LOC, 16'h0001);
		fr(20'h00000, MAKER_CODE);
		fr(20'h00005, c);
		fw(a, 16'h0030);
		qe.push_back({OP_FAST, a, 16'h00D0});
		fw(a, 16'h00D0);
		// A command code in fast mode is only program data
		qe.push_back({OP_FAST_DATA, a, 16'h0070});
		fw(a, 16'h0070);
		fw(r, 16'h00B0);
		wb(0, REG_ENGINE, 0, 32'h20);
		wdone();
		wb(0, REG_ENGINE, 0, 32'h1);
		// Reset with a setup pending and error flags still set
		fw(a, 16'h0040);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, REG_PART, 0, 32'h1111);
		wb(0, REG_STATUS, 0, 32'h80);
		wb(0, REG_CONFIG, 0, 32'h8000);
		complete_run();
	end
endmodule
